// ---- hdl/supervisor_pkg.sv ----
// Shared constants and types for the supply supervisor and watchdog.
// Assumes a 20 MHz free-running clock and an APB master for software access.
// Operation
// RULE1 - Aux fail output low while aux input low
// RULE2 - Watchdog fault low after kick stuck timeout
// RULE3 - Fault stays low until next kick edge
// RULE4 - Floating kick disables watchdog, fault high
// RULE5 - Fault output high while reset asserted
// RULE6 - Manual reset low holds reset, plus stretch
// RULE7 - Unconnected manual reset reads inactive high
// RULE8 - Reset low on low supply or manual
// RULE9 - High reset is inverse of low reset
// RULE10 - Low-line warning low near reset level
// RULE11 - Disabled gate forces chip enable high
// RULE12 - Backup cell chosen below threshold and cell
// RULE13 - Backup active output follows supply selection
// RULE14 - Backup good follows cell comparator
// RULE15 - New dip during stretch restarts timer
// RULE16 - Kick edge clears timer, reset holds cleared
// RULE17 - Gate disabled during reset, enabled after; code keeps it closed after reset while the CTRL_CE_OFF bit is set
// RULE18 - Timeouts are parameterised clock cycle counts
// RULE19 - Kick and manual reset synchronised first
`default_nettype none
package supervisor_pkg;

    // =========================================================
    // Timing
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned STRETCH_MS = 200;
    localparam int unsigned WD_TIMEOUT_MS = 1600;
    localparam int unsigned STRETCH_CYC = CLK_HZ / 1000 * STRETCH_MS;
    localparam int unsigned WD_CYC = CLK_HZ / 1000 * WD_TIMEOUT_MS;
    localparam int unsigned CNT_W = 26;

    // =========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] EVT_STAT_OFS = 8'h08;
    localparam logic [7:0] EVT_CLR_OFS = 8'h0c;
    localparam logic [7:0] EVT_EN_OFS = 8'h10;

    // Control fields
    localparam int unsigned CTRL_CE_OFF = 0;
    localparam logic CTRL_RST = 1'b0;

    // Event fields
    localparam int unsigned EVT_W = 5;
    localparam int unsigned EVT_RESET = 0;
    localparam int unsigned EVT_WD = 1;
    localparam int unsigned EVT_AUX = 2;
    localparam int unsigned EVT_LOW = 3;
    localparam int unsigned EVT_BACKUP = 4;
    localparam logic [4:0] EVT_RST = 5'h00;

    // Status width
    localparam int unsigned STATUS_W = 6;

    // =========================================================
    // Pin inputs, digitised comparators first
    typedef struct packed {
        logic below_reset;     // Supply below reset level
        logic near_reset;      // Supply at low-line level
        logic aux_below;       // Aux input below threshold
        logic cell_good;       // Backup cell above threshold
        logic main_above_cell; // Supply above backup cell
        logic manual_reset_n;  // Manual reset, active low
        logic kick;            // Watchdog kick level
        logic kick_float;      // Kick pin seen floating
        logic ce_n;            // Chip enable to gate
    } pin_in_t;

    // Power-up view: in reset, supply on main, inputs idle
    localparam logic [8:0] PIN_RST = 9'h119;

    // Reset sequencer states
    typedef enum logic [1:0] {
        RST_HOLD = 2'b00,
        RST_STRETCH = 2'b01,
        RST_RUN = 2'b10
    } rst_state_t;

    // Watchdog states
    typedef enum logic [1:0] {
        WD_OFF = 2'b00,
        WD_COUNT = 2'b01,
        WD_FAULT = 2'b10
    } wd_state_t;

endpackage
`default_nettype wire

// ---- hdl/supply_supervisor_watchdog.sv ----
// Supply supervisor: reset stretch, watchdog, backup switch and CE gating.
// Assumes digitised comparator results on pins and an APB master.
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
module supply_supervisor_watchdog #(
    parameter int unsigned STRETCH_CYCLES = supervisor_pkg::STRETCH_CYC,
    parameter int unsigned WATCHDOG_CYCLES = supervisor_pkg::WD_CYC
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // Comparator results and pins
    input wire supervisor_pkg::pin_in_t pins_i,
    // Reset and watchdog outputs
    output logic reset_n_o,
    output logic reset_o,
    output logic watchdog_fault_output_o,
    // Warning and backup outputs
    output logic aux_power_fail_output_o,
    output logic low_line_n_o,
    output logic backup_active_o,
    output logic backup_good_o,
    // Gated chip enable
    output logic chip_enable_n_o,
    // Interrupt
    output logic irq_o,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o
);
    import supervisor_pkg::*;

    // =========================================================
    // Helpers

    // Address maps to a register
    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a == CTRL_OFS) || (a == STATUS_OFS) || (a == EVT_STAT_OFS)
            || (a == EVT_CLR_OFS) || (a == EVT_EN_OFS);
    endfunction

    // =========================================================
    // Reset release
    logic rst_meta_q; // First release stage
    logic rst_n_q; // Released reset for the design

    // Two-stage release, assert at once
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // =========================================================
    // Input synchroniser
    pin_in_t s1_q, s2_q, s3_q; // Three-stage chain
    pin_in_t in_q, in_d; // Accepted levels

    // RULE19 accept when stages agree
    always_comb begin
        in_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & in_q);
    end

    // RULE7 manual reset idles high
    always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            s1_q <= PIN_RST;
            s2_q <= PIN_RST;
            s3_q <= PIN_RST;
            in_q <= PIN_RST;
        end else begin
            s1_q <= pins_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            in_q <= in_d;
        end
    end

    // =========================================================
    // Reset sequencer
    rst_state_t rst_state_q, rst_state_d; // Sequencer state
    logic [CNT_W-1:0] stretch_q, stretch_d; // Stretch cycles
    logic cause; // Any reset cause present
    logic reset_act; // Reset outputs asserted

    // RULE6 RULE8 causes of reset
    assign cause = in_q.below_reset || !in_q.manual_reset_n;

    // Next state of sequencer
    always_comb begin
        rst_state_d = rst_state_q;
        stretch_d = '0;
        case (rst_state_q)
            // Held while a cause stands
            RST_HOLD: begin
                if (!cause) begin
                    rst_state_d = RST_STRETCH;
                end
            end
            // RULE15 RULE18 stretch then release
            RST_STRETCH: begin
                if (cause) begin
                    rst_state_d = RST_HOLD;
                end else if (stretch_q == CNT_W'(STRETCH_CYCLES - 1)) begin
                    rst_state_d = RST_RUN;
                end else begin
                    stretch_d = stretch_q + 1'b1;
                end
            end
            // Running until a new cause
            RST_RUN: begin
                if (cause) begin
                    rst_state_d = RST_HOLD;
                end
            end
            default: begin
                rst_state_d = RST_HOLD;
            end
        endcase
    end

    // Registers only
    always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rst_state_q <= RST_HOLD;
            stretch_q <= '0;
        end else begin
            rst_state_q <= rst_state_d;
            stretch_q <= stretch_d;
        end
    end

    // RULE9 outputs strictly inverse
    assign reset_act = (rst_state_q != RST_RUN);
    assign reset_n_o = !reset_act;
    assign reset_o = reset_act;

    // =========================================================
    // Watchdog
    logic wd_fault_n; // Fault, active low

    // RULE16 held clear in reset
    wd_timer #(
        .LIMIT(WATCHDOG_CYCLES)
    ) u_wd (
        .clk_i(sys_clk_i),
        .rst_n_i(rst_n_q),
        .kick_i(in_q.kick),
        .float_i(in_q.kick_float),
        .hold_i(reset_act),
        .fault_n_o(wd_fault_n)
    );

    assign watchdog_fault_output_o = wd_fault_n;

    // =========================================================
    // Warning, backup and gate outputs
    logic ctrl_ce_off_q, ctrl_ce_off_d; // Software gate off
    logic gate_en_q, gate_en_d; // Chip enable gate open
    logic ce_q, ce_d; // Gated chip enable
    logic aux_fail_q, aux_fail_d; // Aux fail warning
    logic low_q, low_d; // Low-line warning
    logic backup_on_q, backup_on_d; // Backup selected
    logic backup_ok_q, backup_ok_d; // Backup good

    // Next output levels
    always_comb begin
        // RULE1 aux fail follows comparator
        aux_fail_d = !in_q.aux_below;
        // RULE10 low-line follows comparator
        low_d = !in_q.near_reset;
        // RULE12 RULE13 backup selection
        backup_on_d = in_q.below_reset && !in_q.main_above_cell;
        // RULE14 cell good flag
        backup_ok_d = in_q.cell_good;
        // RULE17 gate only outside reset
        gate_en_d = !reset_act && !ctrl_ce_off_q;
        // RULE11 force inactive when closed
        ce_d = gate_en_q ? in_q.ce_n : 1'b1;
    end

    // Registers only
    always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            aux_fail_q <= 1'b1;
            low_q <= 1'b1;
            backup_on_q <= 1'b0;
            backup_ok_q <= 1'b0;
            gate_en_q <= 1'b0;
            ce_q <= 1'b1;
        end else begin
            aux_fail_q <= aux_fail_d;
            low_q <= low_d;
            backup_on_q <= backup_on_d;
            backup_ok_q <= backup_ok_d;
            gate_en_q <= gate_en_d;
            ce_q <= ce_d;
        end
    end

    assign aux_power_fail_output_o = aux_fail_q;
    assign low_line_n_o = low_q;
    assign backup_active_o = backup_on_q;
    assign backup_good_o = backup_ok_q;
    assign chip_enable_n_o = ce_q;

    // =========================================================
    // Events and interrupt
    logic [EVT_W-1:0] lvl; // Event levels
    logic [EVT_W-1:0] prev_q, prev_d; // Levels last cycle
    logic [EVT_W-1:0] stat_q, stat_d; // Sticky status
    logic [EVT_W-1:0] en_q, en_d; // Interrupt enables
    logic [EVT_W-1:0] clr; // Clear strobe
    logic irq_q, irq_d; // Registered interrupt
    logic wr_acc; // APB write taken

    // Rising edges of these levels are events
    always_comb begin
        lvl = '0;
        lvl[EVT_RESET] = reset_act;
        lvl[EVT_WD] = !wd_fault_n;
        lvl[EVT_AUX] = !aux_fail_q;
        lvl[EVT_LOW] = !low_q;
        lvl[EVT_BACKUP] = backup_on_q;
    end

    assign wr_acc = psel_i && penable_i && pwrite_i;
    assign clr = (wr_acc && paddr_i == EVT_CLR_OFS) ? pwdata_i[EVT_W-1:0] : '0;

    // Set wins over a clear in the same cycle
    always_comb begin
        prev_d = lvl;
        stat_d = (stat_q & ~clr) | (lvl & ~prev_q);
        en_d = (wr_acc && paddr_i == EVT_EN_OFS) ? pwdata_i[EVT_W-1:0] : en_q;
        ctrl_ce_off_d = (wr_acc && paddr_i == CTRL_OFS) ? pwdata_i[CTRL_CE_OFF]
            : ctrl_ce_off_q;
        irq_d = |(stat_q & en_q);
    end

    // Registers only
    always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            prev_q <= EVT_RST;
            stat_q <= EVT_RST;
            en_q <= EVT_RST;
            ctrl_ce_off_q <= CTRL_RST;
            irq_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
            stat_q <= stat_d;
            en_q <= en_d;
            ctrl_ce_off_q <= ctrl_ce_off_d;
            irq_q <= irq_d;
        end
    end

    assign irq_o = irq_q;

    // =========================================================
    // APB read side
    logic [31:0] rdata_q, rdata_d; // Read data
    logic err_q, err_d; // Unmapped access

    // Loaded in setup cycle, held through access
    always_comb begin
        rdata_d = rdata_q;
        err_d = err_q;
        if (psel_i && !penable_i) begin
            err_d = !reg_hit(paddr_i);
            rdata_d = '0;
            case (paddr_i)
                CTRL_OFS: rdata_d[CTRL_CE_OFF] = ctrl_ce_off_q;
                STATUS_OFS: rdata_d[STATUS_W-1:0] = {backup_ok_q, backup_on_q, low_q,
                    aux_fail_q, wd_fault_n, reset_n_o};
                EVT_STAT_OFS: rdata_d[EVT_W-1:0] = stat_q;
                EVT_EN_OFS: rdata_d[EVT_W-1:0] = en_q;
                default: rdata_d = '0;
            endcase
        end
    end

    // Registers only
    always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= '0;
            err_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            err_q <= err_d;
        end
    end

    assign prdata_o = rdata_q;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && err_q;

    // =========================================================
    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_q);

    // Cause clears, stretch begins from zero
    sequence release_s;
        rst_state_q == RST_HOLD && !cause ##1 !cause;
    endsequence

    aux_follow_a: assert property ( // RULE1
        in_q.aux_below |=> !aux_power_fail_output_o)
        else $error("aux fail warning not low");
    manual_reset_a: assert property ( // RULE6
        !in_q.manual_reset_n |=> reset_o ##1 reset_o)
        else $error("manual reset did not assert reset");
    stretch_start_a: assert property ( // RULE8
        release_s |-> rst_state_q == RST_STRETCH && stretch_q == '0 && !reset_n_o)
        else $error("stretch did not start cleanly");
    stretch_end_a: assert property ( // RULE8
        rst_state_q == RST_STRETCH && stretch_q == CNT_W'(STRETCH_CYCLES - 1) && !cause
        |=> reset_n_o)
        else $error("reset not released after stretch");
    reset_inverse_a: assert property ( // RULE9
        reset_o != reset_n_o && reset_o == (rst_state_q != RST_RUN))
        else $error("reset outputs not inverse");
    low_line_a: assert property ( // RULE10
        in_q.near_reset |=> !low_line_n_o)
        else $error("low-line warning not low");
    gate_closed_a: assert property ( // RULE11
        reset_o |-> ##2 chip_enable_n_o)
        else $error("chip enable passed during reset");
    backup_sel_a: assert property ( // RULE12
        in_q.below_reset && !in_q.main_above_cell |=> backup_active_o)
        else $error("backup cell not selected");
    main_sel_a: assert property ( // RULE13
        !in_q.below_reset || in_q.main_above_cell |=> !backup_active_o)
        else $error("main supply not selected");
    backup_good_a: assert property ( // RULE14
        in_q.cell_good |=> backup_good_o)
        else $error("backup good flag not high");
    stretch_restart_a: assert property ( // RULE15
        rst_state_q == RST_STRETCH && cause |=> rst_state_q == RST_HOLD ##1 stretch_q == '0)
        else $error("stretch not restarted");
    wd_in_reset_a: assert property ( // RULE5
        reset_o |=> watchdog_fault_output_o)
        else $error("watchdog fault during reset");
endmodule
`default_nettype wire

// ---- hdl/wd_timer.sv ----
// Watchdog timer: faults when the kick level stands still too long.
// Assumes kick and float inputs already synchronised to clk_i.
`timescale 1ns/1ns
`default_nettype none
module wd_timer #(
    parameter int unsigned LIMIT = supervisor_pkg::WD_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Conditions
    input wire logic kick_i,
    input wire logic float_i,
    input wire logic hold_i,
    // Fault, active low
    output logic fault_n_o
);
    import supervisor_pkg::*;

    wd_state_t state_q, state_d; // Timer state
    logic [CNT_W-1:0] cnt_q, cnt_d; // Elapsed cycles
    logic kick_prev_q; // Last kick level
    logic kick_edge; // Kick changed level

    // =========================================================
    // Next state
    assign kick_edge = kick_i ^ kick_prev_q;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        // RULE4 RULE16 disable and clear
        if (hold_i || float_i) begin
            state_d = WD_OFF;
            cnt_d = '0;
        end else begin
            case (state_q)
                // Hold or float just released: start counting
                WD_OFF: begin
                    state_d = WD_COUNT;
                    cnt_d = '0;
                end
                // RULE2 RULE18 timeout count
                WD_COUNT: begin
                    if (kick_edge) begin
                        cnt_d = '0;
                    end else if (cnt_q == CNT_W'(LIMIT - 1)) begin
                        state_d = WD_FAULT;
                        cnt_d = '0;
                    end else begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end
                // RULE3 hold until edge
                WD_FAULT: begin
                    if (kick_edge) begin
                        state_d = WD_COUNT;
                    end
                end
                default: begin
                    state_d = WD_OFF;
                    cnt_d = '0;
                end
            endcase
        end
    end

    // Registers only
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= WD_OFF;
            cnt_q <= '0;
            kick_prev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            kick_prev_q <= kick_i;
        end
    end

    // RULE5 high unless faulted
    assign fault_n_o = (state_q != WD_FAULT);

    // =========================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    wd_timeout_a: assert property ( // RULE2
        state_q == WD_COUNT && cnt_q == CNT_W'(LIMIT - 1) && !kick_edge && !hold_i
        && !float_i |=> !fault_n_o)
        else $error("watchdog did not fault at timeout");
    fault_holds_a: assert property ( // RULE3
        !fault_n_o && !kick_edge && !hold_i && !float_i |=> !fault_n_o)
        else $error("watchdog fault released without kick");
    float_disable_a: assert property ( // RULE4
        float_i |=> fault_n_o && cnt_q == '0)
        else $error("floating kick did not disable watchdog");
    reset_clear_a: assert property ( // RULE5
        hold_i |=> fault_n_o && cnt_q == '0)
        else $error("watchdog active during reset");
    kick_clear_a: assert property ( // RULE16
        state_q == WD_COUNT && kick_edge && !hold_i && !float_i |=> cnt_q == '0)
        else $error("kick edge did not clear timer");
endmodule
`default_nettype wire

// ---- sim/host_model.sv ----
// Host model: toggles the watchdog kick while asked to.
// Assumes the bench clock and the raw reset of the block.
`timescale 1ns/1ns
`default_nettype none
module host_model #(
    parameter int unsigned PERIOD = 20
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Run request and kick level
    input wire logic run_i,
    output logic kick_o
);
    // ==========================================
    // Kick toggler
    int unsigned cnt_q; // Cycles since the last toggle
    // Level stands still unless run_i is high
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q <= 0;
            kick_o <= 1'b0;
        end else if (run_i) begin
            cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
            if (cnt_q == PERIOD - 1) begin
                kick_o <= ~kick_o;
            end
        end
    end
endmodule
`default_nettype wire

// ---- sim/supply_supervisor_watchdog_bench.sv ----
// Bench for the supply supervisor: pin table, stretch, watchdog, gate, APB.
// Assumes the host model and short stretch and watchdog counts.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin err_total++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module supply_supervisor_watchdog_bench;
    import supervisor_pkg::*;
    // ==========================================
    // Signals
    localparam int SC = 20; // Short stretch count
    localparam int WC = 50; // Short watchdog count
    logic sys_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    pin_in_t pins_drv = 9'h03a; // Pins driven by the bench
    pin_in_t pins_w; // Pins with the host kick merged in
    logic host_kick;
    logic run_kick = 1'b0;
    logic reset_n_o, reset_o, watchdog_fault_output_o, aux_power_fail_output_o;
    logic low_line_n_o, backup_active_o, backup_good_o, chip_enable_n_o, irq_o;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata_o, rd;
    logic pready_o, pslverr_o, er;
    logic [5:0] got;
    int n, err_total = 0, samples_checked = 0, cyc = 0;
    // Rows: pins, then {reset_n, aux, low_line, backup_active, backup_good, ce}
    logic [8:0] row_pin [6] = '{9'h03a, 9'h0db, 9'h1aa, 9'h1ba, 9'h032, 9'h03b};
    logic [5:0] row_exp [6] = '{6'h3a, 6'h21, 6'h17, 6'h13, 6'h1b, 6'h3b};
    assign pins_w = {pins_drv[8:3], host_kick, pins_drv[1:0]};
    // ==========================================
    // Instances
    supply_supervisor_watchdog #(.STRETCH_CYCLES(SC), .WATCHDOG_CYCLES(WC)) dut_u (
        .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .pins_i(pins_w),
        .reset_n_o(reset_n_o), .reset_o(reset_o),
        .watchdog_fault_output_o(watchdog_fault_output_o),
        .aux_power_fail_output_o(aux_power_fail_output_o), .low_line_n_o(low_line_n_o),
        .backup_active_o(backup_active_o), .backup_good_o(backup_good_o),
        .chip_enable_n_o(chip_enable_n_o), .irq_o(irq_o),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o));
    host_model #(.PERIOD(20)) host_u (
        .clk_i(sys_clk_i), .resetn_i(resetn_i), .run_i(run_kick), .kick_o(host_kick));
    // ==========================================
    // Clock and timeout
    initial begin
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 6000) begin
            err_total++;
            summarize();
        end
    end
    // ==========================================
    // Tasks
    task automatic summarize;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
        @(posedge sys_clk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge sys_clk_i);
        penable <= 1'b1;
        @(posedge sys_clk_i);
        while (pready_o !== 1'b1) begin
            @(posedge sys_clk_i);
        end
        rd = prdata_o;
        er = pslverr_o;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Count edges until reset_n_o or the fault output reaches lvl
    task automatic wait_lvl(input bit wd, input logic lvl);
        n = 0;
        while ((wd ? watchdog_fault_output_o : reset_n_o) !== lvl && n < 2000) begin
            @(posedge sys_clk_i);
            n++;
        end
    endtask
    task automatic pulse_manual;
        pins_drv.manual_reset_n <= 1'b0;
        repeat (10) @(posedge sys_clk_i);
        pins_drv.manual_reset_n <= 1'b1;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        repeat (2) @(posedge sys_clk_i);
        `CHK("rst wd", 1'b1, watchdog_fault_output_o)
        `CHK("rst ce", 2'b10, {chip_enable_n_o, reset_n_o})
        resetn_i <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            pins_drv <= row_pin[i];
            repeat (40) @(posedge sys_clk_i);
            got = {reset_n_o, aux_power_fail_output_o, low_line_n_o, backup_active_o,
                   backup_good_o, chip_enable_n_o};
            `CHK("pin row", row_exp[i], got)
            `CHK("reset pair", ~row_exp[i][5], reset_o)
            `CHK("wd float", 1'b1, watchdog_fault_output_o)
        end
        pulse_manual();
        wait_lvl(0, 1'b1);
        `CHK("stretch", 1'b1, n >= SC + 2 && n <= SC + 7)
        pulse_manual();
        repeat (10) @(posedge sys_clk_i);
        pins_drv.below_reset <= 1'b1;
        repeat (6) @(posedge sys_clk_i);
        pins_drv.below_reset <= 1'b0;
        wait_lvl(0, 1'b1);
        `CHK("restart", 1'b1, n >= SC + 2 && n <= SC + 7)
        pins_drv <= 9'h038;
        @(posedge sys_clk_i);
        pulse_manual();
        wait_lvl(0, 1'b1);
        wait_lvl(1, 1'b0);
        `CHK("wd timeout", 1'b1, n >= WC - 2 && n <= WC + 4)
        repeat (30) @(posedge sys_clk_i);
        `CHK("wd held", 1'b0, watchdog_fault_output_o)
        run_kick <= 1'b1;
        repeat (35) @(posedge sys_clk_i);
        `CHK("wd kick", 1'b1, watchdog_fault_output_o)
        n = 0;
        repeat (150) begin
            @(posedge sys_clk_i);
            if (watchdog_fault_output_o !== 1'b1) n++;
        end
        `CHK("wd kept", 0, n)
        run_kick <= 1'b0;
        repeat (WC + 20) @(posedge sys_clk_i);
        pins_drv.manual_reset_n <= 1'b0;
        repeat (8) @(posedge sys_clk_i);
        `CHK("wd in reset", 1'b1, watchdog_fault_output_o)
        pins_drv <= 9'h03a;
        repeat (SC + WC + 40) @(posedge sys_clk_i);
        `CHK("wd floating", 1'b1, watchdog_fault_output_o)
        `CHK("ce open", 1'b0, chip_enable_n_o)
        apb(1'b1, CTRL_OFS, 32'h1);
        repeat (4) @(posedge sys_clk_i);
        `CHK("ce forced", 1'b1, chip_enable_n_o)
        apb(1'b1, CTRL_OFS, 32'h0);
        repeat (4) @(posedge sys_clk_i);
        `CHK("ce back", 1'b0, chip_enable_n_o)
        apb(1'b1, EVT_EN_OFS, 32'h0);
        apb(1'b1, EVT_CLR_OFS, 32'h1f);
        apb(1'b0, EVT_STAT_OFS, 32'h0);
        `CHK("evt clear", 32'h0, rd)
        apb(1'b1, EVT_EN_OFS, 32'h4);
        pins_drv.aux_below <= 1'b1;
        repeat (10) @(posedge sys_clk_i);
        `CHK("irq set", 1'b1, irq_o)
        apb(1'b0, EVT_STAT_OFS, 32'h0);
        `CHK("evt aux", 32'h4, rd)
        apb(1'b1, EVT_EN_OFS, 32'h0);
        repeat (2) @(posedge sys_clk_i);
        `CHK("irq mask", 1'b0, irq_o)
        apb(1'b1, EVT_EN_OFS, 32'h4);
        repeat (2) @(posedge sys_clk_i);
        `CHK("irq unmask", 1'b1, irq_o)
        pins_drv.aux_below <= 1'b0;
        repeat (10) @(posedge sys_clk_i);
        apb(1'b1, EVT_CLR_OFS, 32'h4);
        repeat (2) @(posedge sys_clk_i);
        `CHK("irq clear", 1'b0, irq_o)
        apb(1'b0, STATUS_OFS, 32'h0);
        `CHK("status", 32'h2f, rd)
        apb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped", 33'h1_0000_0000, {er, rd})
        summarize();
    end
endmodule
`default_nettype wire
